// ===== hw/rmp_consts.svh
`ifndef RMP_CONSTS_SVH
`define RMP_CONSTS_SVH

// Register byte offsets
`define RMP_OFS_DATA_LO   8'h00
`define RMP_OFS_DATA_HI   8'h04
`define RMP_OFS_DIR_LO    8'h08
`define RMP_OFS_DIR_HI    8'h0C
`define RMP_OFS_PULL_LO   8'h10
`define RMP_OFS_PULL_HI   8'h14
`define RMP_OFS_CTRL      8'h18
`define RMP_OFS_CAUSE     8'h1C
`define RMP_OFS_STATUS    8'h20

// Control register fields
`define RMP_CTRL_IRQ_EN      0
`define RMP_CTRL_IRQ_RISE    1
`define RMP_CTRL_IRQ_PULL    2
`define RMP_CTRL_STOP_SELF   3
`define RMP_CTRL_OSC_RANGE   4
`define RMP_CTRL_EXT_OSC     5
`define RMP_CTRL_DBG_OUT_EN  6
`define RMP_CTRL_DBG_DATA    7
`define RMP_CTRL_W           8
`define RMP_CTRL_RESET       8'h00

// Reset cause register fields
`define RMP_CAUSE_POR     8'h80
`define RMP_CAUSE_PIN     8'h40
`define RMP_CAUSE_WDOG    8'h20
`define RMP_CAUSE_ILOP    8'h10
`define RMP_CAUSE_ILAD    8'h08
`define RMP_CAUSE_LVD     8'h02
`define RMP_CAUSE_NONE    8'h00

// Status register fields
`define RMP_STAT_BGND     0
`define RMP_STAT_IN_RST   1

// Reset sequence, in self-clock cycles
`define RMP_RST_DRIVE_CYC  6'h22
`define RMP_RST_SAMPLE_CYC 6'h26
`define RMP_CNT_W          6

// Debug link bit time, in debug clock cycles
`define RMP_DBG_BIT_CYC    5'h10
`define RMP_DBG_CNT_W      5

// Shared pins
`define RMP_NPINS          55
`define RMP_OSC_OUT_IDX    48
`define RMP_OSC_IN_IDX     49
`define RMP_KBI_UP_LO      4
`define RMP_KBI_UP_N       4

// AXI responses
`define RMP_RESP_OKAY      2'h0
`define RMP_RESP_SLVERR    2'h2
`endif

// ===== hw/rmp_pad_cell.sv
`timescale 1ns/10ps
`default_nettype none

module rmp_pad_cell (
  // Reset state
  input  wire logic in_reset,
  // Port register bits
  input  wire logic dir,
  input  wire logic data,
  input  wire logic pull_en,
  // Peripheral ownership
  input  wire logic periph_en,
  input  wire logic periph_oe,
  input  wire logic periph_out,
  input  wire logic force_pull,
  input  wire logic pull_down_sel,
  // Pad side
  input  wire logic pad_in_sync,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pull_up,
  output logic      pull_down,
  output logic      rd_value
);

  logic owned;
  logic pull_on;

  // Peripheral drives the buffer enable, otherwise the direction bit
  assign owned    = periph_en & ~in_reset;
  assign pad_oe   = in_reset ? 1'b0 : (owned ? periph_oe : dir);
  assign pad_out  = owned ? periph_out : data;
  // Direction bit picks latch or pin on read, owner or not
  assign rd_value = dir ? data : pad_in_sync;

  // Pull only while acting as input, and never in reset
  assign pull_on   = ~in_reset & ~pad_oe & (pull_en | force_pull);
  assign pull_down = pull_on & pull_down_sel;
  assign pull_up   = pull_on & ~pull_down_sel;

endmodule

`default_nettype wire

// ===== hw/rmp_pkg.sv
package rmp_pkg;
  // Reset sequencer states
  typedef enum logic [2:0] {
    RS_DRIVE,
    RS_WAIT,
    RS_SAMPLE,
    RS_RUN
  } rmp_rst_state_t;
endpackage

// ===== hw/rmp_top.sv
// Behaviour
// - On any reset drive reset pin low 34 self-clocks, release, sample 38 later.
// - After an internal reset the delayed reset pin sample is expected high.
// - Decode the reset cause and set its bit in the reset cause register.
// - Reset sequence is timed by the internal self-clock of roughly 8 MHz.
// - Self-clock is selectable as stop-recovery clock source.
// - Debug pin is mode select during reset, debug link right after.
// - At reset release pin high gives normal mode, pin low gives background mode.
// - Debug pin used as port bit is output only.
// - Debug link bit time is 16 debug clocks; debug clock may equal bus clock.
// - Debug pin is pseudo open drain with brief driven-high speedup pulses.
// - After reset all 55 shared pins are inputs with pulls off.
// - Peripheral owns output enable; direction bit still selects port read value.
// - Pull enable turns on pull whenever pin acts as input, even peripheral owned.
// - Upper four keypad pins at rising or high sensitivity get pulldown instead.
// - External interrupt pin set for rising edges gets pulldown instead of pullup.
// - With external oscillator driving the input, oscillator output pin is GPIO.
// - Range bit in clock control selects one of two crystal frequency ranges.
// - External interrupt function and its pull active only when pin enable set.
// - Keypad pin enabled falling forces pullup; enabled rising forces pulldown.
`timescale 1ns/10ps
`default_nettype none
`include "rmp_consts.svh"

module rmp_top
  import rmp_pkg::*;
#(
  parameter int NPINS    = `RMP_NPINS,
  parameter int SELF_DIV = 1
) (
  // Clock and reset
  input  wire logic             CLOCK,
  input  wire logic             SRST,
  // AXI4-Lite write address and data
  input  wire logic [7:0]       S_AXI_AWADDR,
  input  wire logic             S_AXI_AWVALID,
  output logic                  S_AXI_AWREADY,
  input  wire logic [31:0]      S_AXI_WDATA,
  input  wire logic [3:0]       S_AXI_WSTRB,
  input  wire logic             S_AXI_WVALID,
  output logic                  S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]            S_AXI_BRESP,
  output logic                  S_AXI_BVALID,
  input  wire logic             S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]       S_AXI_ARADDR,
  input  wire logic             S_AXI_ARVALID,
  output logic                  S_AXI_ARREADY,
  output logic [31:0]           S_AXI_RDATA,
  output logic [1:0]            S_AXI_RRESP,
  output logic                  S_AXI_RVALID,
  input  wire logic             S_AXI_RREADY,
  // Internal reset sources
  input  wire logic             LVD_RESET,
  input  wire logic             WDOG_RESET,
  input  wire logic             ILOP_RESET,
  input  wire logic             ILAD_RESET,
  // Reset pin
  input  wire logic             RESET_PIN_IN,
  output logic                  RESET_PIN_OUT,
  output logic                  RESET_PIN_OE,
  output logic                  SYS_RESET,
  // Debug mode select pin
  input  wire logic             DEBUG_LINK_PIN_IN,
  output logic                  DEBUG_LINK_PIN_OUT,
  output logic                  DEBUG_LINK_PIN_OE,
  output logic                  DEBUG_LINK_PULLUP,
  // Debug serial controller side
  input  wire logic             DBG_DRIVE_LOW,
  input  wire logic             DBG_SPEEDUP,
  output logic                  DBG_LINK_LEVEL,
  output logic                  DBG_BIT_TICK,
  output logic                  ACTIVE_BGND_MODE,
  // Clock generator controls
  output logic                  STOP_CLK_SELF,
  output logic                  OSC_RANGE_HIGH,
  // External interrupt pin
  input  wire logic             IRQ_PIN_IN,
  output logic                  IRQ_PULLUP,
  output logic                  IRQ_PULLDOWN,
  output logic                  IRQ_LEVEL,
  // Keypad unit controls for upper port bits
  input  wire logic [3:0]       KBI_UP_EN,
  input  wire logic [3:0]       KBI_UP_RISE,
  // Peripheral ownership of shared pins
  input  wire logic [NPINS-1:0] PERIPH_EN,
  input  wire logic [NPINS-1:0] PERIPH_OE,
  input  wire logic [NPINS-1:0] PERIPH_OUT,
  // Shared pins
  input  wire logic [NPINS-1:0] PAD_IN,
  output logic [NPINS-1:0]      PAD_OUT,
  output logic [NPINS-1:0]      PAD_OE,
  output logic [NPINS-1:0]      PAD_PULLUP,
  output logic [NPINS-1:0]      PAD_PULLDOWN
);

  localparam int HIW = NPINS - 32;

  rmp_rst_state_t              state_ff;
  logic [`RMP_CNT_W-1:0]       cnt_ff;
  logic [7:0]                  cause_ff;
  logic                        bgnd_ff;
  logic [15:0]                 div_ff;
  logic                        self_tick;
  logic                        in_reset;
  logic [NPINS-1:0]            pad_s1_ff, pad_s2_ff;
  logic [2:0]                  ctl_s1_ff, ctl_s2_ff;
  logic                        rst_pin_s, dbg_pin_s, irq_pin_s;
  logic [NPINS-1:0]            data_ff, dir_ff, pull_ff;
  logic [`RMP_CTRL_W-1:0]      ctrl_ff;
  logic [`RMP_DBG_CNT_W-1:0]   bit_cnt_ff;
  logic                        aw_got_ff, w_got_ff;
  logic [7:0]                  awaddr_ff;
  logic [31:0]                 wdata_ff;
  logic [3:0]                  wstrb_ff;
  logic                        do_write;
  logic                        wr_hit;
  logic [31:0]                 nxt_rdata;
  logic                        rd_hit;
  logic [NPINS-1:0]            rd_value;
  logic [NPINS-1:0]            eff_en, eff_oe, force_pull, pd_sel;
  logic [63:0]                 rd_wide, dir_wide, data_wide, pull_wide;

  // Byte lanes merged into an old word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Self-clock enable; approximates the reset-time oscillator
  always_ff @(posedge CLOCK) begin
    if (SRST || div_ff == 16'(SELF_DIV - 1)) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  assign self_tick = (div_ff == 16'(SELF_DIV - 1));

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge CLOCK) begin
    pad_s1_ff <= PAD_IN;
    pad_s2_ff <= pad_s1_ff;
    ctl_s1_ff <= {IRQ_PIN_IN, DEBUG_LINK_PIN_IN, RESET_PIN_IN};
    ctl_s2_ff <= ctl_s1_ff;
  end
  assign rst_pin_s = ctl_s2_ff[0];
  assign dbg_pin_s = ctl_s2_ff[1];
  assign irq_pin_s = ctl_s2_ff[2];

  // Reset sequencer; SRST counts as power-on
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_ff <= RS_DRIVE;
      cnt_ff   <= '0;
      cause_ff <= `RMP_CAUSE_POR;
    end else begin
      unique case (state_ff)
        RS_RUN: begin
          if (LVD_RESET | WDOG_RESET | ILOP_RESET | ILAD_RESET) begin
            state_ff <= RS_DRIVE;
            cnt_ff   <= '0;
            cause_ff <= (LVD_RESET ? `RMP_CAUSE_LVD : `RMP_CAUSE_NONE)
                      | (WDOG_RESET ? `RMP_CAUSE_WDOG : `RMP_CAUSE_NONE)
                      | (ILOP_RESET ? `RMP_CAUSE_ILOP : `RMP_CAUSE_NONE)
                      | (ILAD_RESET ? `RMP_CAUSE_ILAD : `RMP_CAUSE_NONE);
          end else if (!rst_pin_s) begin
            state_ff <= RS_DRIVE;
            cnt_ff   <= '0;
            cause_ff <= `RMP_CAUSE_PIN;
          end
        end
        RS_DRIVE: begin
          if (self_tick) begin
            if (cnt_ff == `RMP_RST_DRIVE_CYC - 6'h01) begin
              state_ff <= RS_WAIT;
              cnt_ff   <= '0;
            end else begin
              cnt_ff <= cnt_ff + 6'h01;
            end
          end
        end
        RS_WAIT: begin
          if (self_tick) begin
            if (cnt_ff == `RMP_RST_SAMPLE_CYC - 6'h01) begin
              state_ff <= RS_SAMPLE;
              cnt_ff   <= '0;
            end else begin
              cnt_ff <= cnt_ff + 6'h01;
            end
          end
        end
        RS_SAMPLE: begin
          // Low sample means someone outside still holds the pin
          if (self_tick) begin
            if (rst_pin_s) begin
              state_ff <= RS_RUN;
            end else begin
              cause_ff <= cause_ff | `RMP_CAUSE_PIN;
            end
          end
        end
        default: begin
          state_ff <= RS_DRIVE;
        end
      endcase
    end
  end

  assign in_reset      = (state_ff != RS_RUN);
  assign SYS_RESET     = in_reset;
  assign RESET_PIN_OUT = 1'b0;
  assign RESET_PIN_OE  = (state_ff == RS_DRIVE);

  // Mode latch at the release cycle, held until the next release; SRST clears it
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      bgnd_ff <= 1'b0;
    end else if (state_ff == RS_SAMPLE && self_tick && rst_pin_s) begin
      bgnd_ff <= ~dbg_pin_s;
    end
  end
  assign ACTIVE_BGND_MODE = bgnd_ff;

  // Debug bit timer at bus rate, 16 clocks a bit
  always_ff @(posedge CLOCK) begin
    if (SRST || in_reset || bit_cnt_ff == `RMP_DBG_BIT_CYC - 5'h01) begin
      bit_cnt_ff <= '0;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end
  assign DBG_BIT_TICK = ~in_reset && (bit_cnt_ff == `RMP_DBG_BIT_CYC - 5'h01);

  // Debug pin: input in reset, link or output-only port after
  always_comb begin
    DEBUG_LINK_PIN_OE  = 1'b0;
    DEBUG_LINK_PIN_OUT = 1'b0;
    if (!in_reset) begin
      if (DBG_DRIVE_LOW | DBG_SPEEDUP) begin
        DEBUG_LINK_PIN_OE  = 1'b1;
        DEBUG_LINK_PIN_OUT = DBG_SPEEDUP & ~DBG_DRIVE_LOW;
      end else if (ctrl_ff[`RMP_CTRL_DBG_OUT_EN]) begin
        DEBUG_LINK_PIN_OE  = 1'b1;
        DEBUG_LINK_PIN_OUT = ctrl_ff[`RMP_CTRL_DBG_DATA];
      end
    end
  end
  assign DEBUG_LINK_PULLUP = in_reset | ~ctrl_ff[`RMP_CTRL_DBG_OUT_EN];
  assign DBG_LINK_LEVEL    = dbg_pin_s & ~in_reset;

  // Clock generator controls
  assign STOP_CLK_SELF  = ctrl_ff[`RMP_CTRL_STOP_SELF];
  assign OSC_RANGE_HIGH = ctrl_ff[`RMP_CTRL_OSC_RANGE];

  // External interrupt pin pulls, only while its function is on
  assign IRQ_PULLDOWN = ~in_reset & ctrl_ff[`RMP_CTRL_IRQ_EN] & ctrl_ff[`RMP_CTRL_IRQ_PULL]
                        & ctrl_ff[`RMP_CTRL_IRQ_RISE];
  assign IRQ_PULLUP   = ~in_reset & ctrl_ff[`RMP_CTRL_IRQ_EN] & ctrl_ff[`RMP_CTRL_IRQ_PULL]
                        & ~ctrl_ff[`RMP_CTRL_IRQ_RISE];
  assign IRQ_LEVEL    = irq_pin_s & ctrl_ff[`RMP_CTRL_IRQ_EN];

  // Ownership overrides: oscillator pins and upper keypad bits
  always_comb begin
    eff_en     = PERIPH_EN;
    eff_oe     = PERIPH_OE;
    force_pull = '0;
    pd_sel     = '0;
    eff_en[`RMP_OSC_IN_IDX] = 1'b1;
    eff_oe[`RMP_OSC_IN_IDX] = 1'b0;
    if (!ctrl_ff[`RMP_CTRL_EXT_OSC]) begin
      eff_en[`RMP_OSC_OUT_IDX] = 1'b1;
      eff_oe[`RMP_OSC_OUT_IDX] = 1'b0;
    end else begin
      eff_en[`RMP_OSC_OUT_IDX] = 1'b0;
    end
    for (int k = 0; k < `RMP_KBI_UP_N; k++) begin
      if (KBI_UP_EN[k]) begin
        eff_en[`RMP_KBI_UP_LO + k]     = 1'b1;
        eff_oe[`RMP_KBI_UP_LO + k]     = 1'b0;
        force_pull[`RMP_KBI_UP_LO + k] = 1'b1;
        pd_sel[`RMP_KBI_UP_LO + k]     = KBI_UP_RISE[k];
      end
    end
  end

  // One pad cell per shared pin
  for (genvar i = 0; i < NPINS; i++) begin : g_pad
    rmp_pad_cell u_pad (
      .in_reset      (in_reset),
      .dir           (dir_ff[i]),
      .data          (data_ff[i]),
      .pull_en       (pull_ff[i]),
      .periph_en     (eff_en[i]),
      .periph_oe     (eff_oe[i]),
      .periph_out    (PERIPH_OUT[i]),
      .force_pull    (force_pull[i]),
      .pull_down_sel (pd_sel[i]),
      .pad_in_sync   (pad_s2_ff[i]),
      .pad_out       (PAD_OUT[i]),
      .pad_oe        (PAD_OE[i]),
      .pull_up       (PAD_PULLUP[i]),
      .pull_down     (PAD_PULLDOWN[i]),
      .rd_value      (rd_value[i])
    );
  end

  // AXI write channel capture, either order
  assign S_AXI_AWREADY = ~aw_got_ff & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_got_ff & ~S_AXI_BVALID;
  assign do_write      = aw_got_ff & w_got_ff & ~S_AXI_BVALID;
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RMP_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? `RMP_RESP_OKAY : `RMP_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Write decode; status words are read-only but mapped
  always_comb begin
    unique case (awaddr_ff)
      `RMP_OFS_DATA_LO, `RMP_OFS_DATA_HI, `RMP_OFS_DIR_LO, `RMP_OFS_DIR_HI,
      `RMP_OFS_PULL_LO, `RMP_OFS_PULL_HI, `RMP_OFS_CTRL, `RMP_OFS_CAUSE,
      `RMP_OFS_STATUS: wr_hit = 1'b1;
      default:         wr_hit = 1'b0;
    endcase
  end

  // Widened copies so both words share one decode
  assign dir_wide  = {{(64-NPINS){1'b0}}, dir_ff};
  assign data_wide = {{(64-NPINS){1'b0}}, data_ff};
  assign pull_wide = {{(64-NPINS){1'b0}}, pull_ff};
  assign rd_wide   = {{(64-NPINS){1'b0}}, rd_value};

  // Port registers; reset leaves all pins floating inputs
  always_ff @(posedge CLOCK) begin
    if (SRST || in_reset) begin
      data_ff <= '0;
      dir_ff  <= '0;
      pull_ff <= '0;
    end else if (do_write) begin
      unique case (awaddr_ff)
        `RMP_OFS_DATA_LO: data_ff[31:0]       <= merge_bytes(data_wide[31:0], wdata_ff, wstrb_ff);
        `RMP_OFS_DATA_HI: data_ff[NPINS-1:32] <= HIW'(merge_bytes(data_wide[63:32], wdata_ff, wstrb_ff));
        `RMP_OFS_DIR_LO:  dir_ff[31:0]        <= merge_bytes(dir_wide[31:0], wdata_ff, wstrb_ff);
        `RMP_OFS_DIR_HI:  dir_ff[NPINS-1:32]  <= HIW'(merge_bytes(dir_wide[63:32], wdata_ff, wstrb_ff));
        `RMP_OFS_PULL_LO: pull_ff[31:0]       <= merge_bytes(pull_wide[31:0], wdata_ff, wstrb_ff);
        `RMP_OFS_PULL_HI: pull_ff[NPINS-1:32] <= HIW'(merge_bytes(pull_wide[63:32], wdata_ff, wstrb_ff));
        default: ;
      endcase
    end
  end

  // Control register; kept through sequencer resets, cleared by SRST
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl_ff <= `RMP_CTRL_RESET;
    end else if (do_write && awaddr_ff == `RMP_OFS_CTRL && wstrb_ff[0]) begin
      ctrl_ff <= wdata_ff[`RMP_CTRL_W-1:0];
    end
  end

  // Read decode
  always_comb begin
    rd_hit    = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      `RMP_OFS_DATA_LO: nxt_rdata = rd_wide[31:0];
      `RMP_OFS_DATA_HI: nxt_rdata = rd_wide[63:32];
      `RMP_OFS_DIR_LO:  nxt_rdata = dir_wide[31:0];
      `RMP_OFS_DIR_HI:  nxt_rdata = dir_wide[63:32];
      `RMP_OFS_PULL_LO: nxt_rdata = pull_wide[31:0];
      `RMP_OFS_PULL_HI: nxt_rdata = pull_wide[63:32];
      `RMP_OFS_CTRL:    nxt_rdata = {24'h000000, ctrl_ff};
      `RMP_OFS_CAUSE:   nxt_rdata = {24'h000000, cause_ff};
      `RMP_OFS_STATUS: begin
        nxt_rdata[`RMP_STAT_BGND]   = bgnd_ff;
        nxt_rdata[`RMP_STAT_IN_RST] = in_reset;
      end
      default:          rd_hit = 1'b0;
    endcase
  end

  // AXI read channel, answer one cycle after address
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `RMP_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= nxt_rdata;
      S_AXI_RRESP  <= rd_hit ? `RMP_RESP_OKAY : `RMP_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== tb/rmp_checker.sv
`timescale 1ns/10ps
`default_nettype none
module rmp_checker #(
  parameter int NPINS = 55
) (
  // Clock and reset
  input wire logic             CLOCK,
  input wire logic             SRST,
  // Reset sources and pin
  input wire logic             LVD_RESET,
  input wire logic             WDOG_RESET,
  input wire logic             ILOP_RESET,
  input wire logic             ILAD_RESET,
  input wire logic             RESET_PIN_OUT,
  input wire logic             RESET_PIN_OE,
  input wire logic             SYS_RESET,
  // Debug pin
  input wire logic             DEBUG_LINK_PIN_OUT,
  input wire logic             DEBUG_LINK_PIN_OE,
  input wire logic             DEBUG_LINK_PULLUP,
  input wire logic             DBG_DRIVE_LOW,
  input wire logic             DBG_BIT_TICK,
  input wire logic             ACTIVE_BGND_MODE,
  // Shared pins
  input wire logic [3:0]       KBI_UP_EN,
  input wire logic [3:0]       KBI_UP_RISE,
  input wire logic [NPINS-1:0] PERIPH_EN,
  input wire logic [NPINS-1:0] PERIPH_OE,
  input wire logic [NPINS-1:0] PAD_OE,
  input wire logic [NPINS-1:0] PAD_PULLUP,
  input wire logic [NPINS-1:0] PAD_PULLDOWN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  logic [7:0] oe_cnt_ff;
  // Drive length; sentinel skips the run begun inside reset
  always_ff @(posedge CLOCK) begin
    if (SRST) oe_cnt_ff <= 8'hFF;
    else if (!RESET_PIN_OE) oe_cnt_ff <= 8'h00;
    else if (oe_cnt_ff != 8'hFF) oe_cnt_ff <= oe_cnt_ff + 8'h01;
  end
  a_drive_len: assert property ($fell(RESET_PIN_OE) && oe_cnt_ff != 8'hFF |-> oe_cnt_ff == 8'h22)
    else $error("reset pin drive length wrong");
  a_release_gap: assert property ($fell(RESET_PIN_OE) |-> ##37 SYS_RESET)
    else $error("reset sample too early");
  a_int_start: assert property ((LVD_RESET || WDOG_RESET || ILOP_RESET || ILAD_RESET) && !SYS_RESET
    |=> SYS_RESET && RESET_PIN_OE) else $error("internal reset not started");
  a_pin_low: assert property (RESET_PIN_OE |-> !RESET_PIN_OUT)
    else $error("reset pin driven high");
  a_mode_hold: assert property (!SYS_RESET && !$past(SYS_RESET) |-> $stable(ACTIVE_BGND_MODE))
    else $error("mode changed while running");
  a_dbg_reset: assert property (SYS_RESET |-> !DEBUG_LINK_PIN_OE && DEBUG_LINK_PULLUP)
    else $error("debug pin not mode input in reset");
  a_bit_time: assert property (DBG_BIT_TICK |=> !DBG_BIT_TICK [*8] ##8 (DBG_BIT_TICK || SYS_RESET))
    else $error("bit tick spacing wrong");
  a_dbg_low: assert property (DBG_DRIVE_LOW && !SYS_RESET |-> DEBUG_LINK_PIN_OE && !DEBUG_LINK_PIN_OUT)
    else $error("debug pin not pulled low");
  a_pads_idle: assert property (SYS_RESET && PERIPH_EN == '0 && KBI_UP_EN == 4'h0
    |-> PAD_OE[47:0] == '0 && PAD_PULLUP == '0 && PAD_PULLDOWN == '0) else $error("pads active in reset");
  a_kbi_down: assert property (!SYS_RESET && KBI_UP_EN[1] && KBI_UP_RISE[1]
    |-> PAD_PULLDOWN[5] && !PAD_PULLUP[5]) else $error("keypad pull wrong");
  a_periph_oe: assert property (!SYS_RESET && PERIPH_EN[1] |-> PAD_OE[1] == PERIPH_OE[1])
    else $error("peripheral enable not passed");
endmodule
bind rmp_top rmp_checker #(.NPINS(NPINS)) i_chk (.*);
`default_nettype wire

// ===== tb/rmp_pod.sv
`timescale 1ns/10ps
`default_nettype none
module rmp_pod (
  // Device side
  input wire logic rst_oe,
  input wire logic dbg_oe,
  input wire logic dbg_out,
  // Bench controls
  input wire logic hold_rst,
  input wire logic hold_dbg,
  // Wire levels
  output logic     rst_lvl,
  output logic     dbg_lvl
);
  // Board pullup; switch or pod pulls the line low
  assign rst_lvl = !(rst_oe || hold_rst);
  // Pod holds mode low, else pullup unless driven
  assign dbg_lvl = hold_dbg ? 1'b0 : (dbg_oe ? dbg_out : 1'b1);
endmodule
`default_nettype wire

// ===== tb/test_reset_mode_and_pad_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_reset_mode_and_pad_control;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r_data;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [1:0] rresp, r_resp;
  logic [3:0] src = 4'h0, kbi_en = 4'h0, kbi_rise = 4'h0;
  logic dbg_lo = 0, spd = 0, hold_rst = 0, hold_dbg = 0;
  logic [54:0] p_en = '0, p_oe = '0, pad_oe, pad_pu, pad_pd;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, rst_oe, sys_rst, rst_lvl, dbg_lvl;
  logic dbg_oe, dbg_out, bgnd, stop_self, range_hi, irq_pu, irq_pd, irq_lvl;
  int n_fail = 0, checks = 0;
  logic [7:0] cause [4] = '{8'h02, 8'h20, 8'h10, 8'h08};
  logic [7:0] ctl [6] = '{8'h07, 8'h05, 8'h06, 8'h18, 8'hC0, 8'h20};
  logic [6:0] cx [6] = '{7'h50, 7'h60, 7'h00, 7'h0C, 7'h03, 7'h00};
  // Self clock approximated at bus rate
  always #50 clk = ~clk;
  rmp_top i_dut (
    .CLOCK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(), .S_AXI_BVALID(b_vld), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_vld), .S_AXI_RREADY(rready), .LVD_RESET(src[0]), .WDOG_RESET(src[1]),
    .ILOP_RESET(src[2]), .ILAD_RESET(src[3]), .RESET_PIN_IN(rst_lvl), .RESET_PIN_OUT(),
    .RESET_PIN_OE(rst_oe), .SYS_RESET(sys_rst), .DEBUG_LINK_PIN_IN(dbg_lvl),
    .DEBUG_LINK_PIN_OUT(dbg_out), .DEBUG_LINK_PIN_OE(dbg_oe), .DEBUG_LINK_PULLUP(),
    .DBG_DRIVE_LOW(dbg_lo), .DBG_SPEEDUP(spd), .DBG_LINK_LEVEL(), .DBG_BIT_TICK(),
    .ACTIVE_BGND_MODE(bgnd), .STOP_CLK_SELF(stop_self), .OSC_RANGE_HIGH(range_hi),
    .IRQ_PIN_IN(1'b1), .IRQ_PULLUP(irq_pu), .IRQ_PULLDOWN(irq_pd), .IRQ_LEVEL(irq_lvl),
    .KBI_UP_EN(kbi_en), .KBI_UP_RISE(kbi_rise), .PERIPH_EN(p_en), .PERIPH_OE(p_oe),
    .PERIPH_OUT('0), .PAD_IN('0), .PAD_OUT(), .PAD_OE(pad_oe), .PAD_PULLUP(pad_pu),
    .PAD_PULLDOWN(pad_pd));
  rmp_pod i_pod (.rst_oe(rst_oe), .dbg_oe(dbg_oe), .dbg_out(dbg_out), .hold_rst(hold_rst),
    .hold_dbg(hold_dbg), .rst_lvl(rst_lvl), .dbg_lvl(dbg_lvl));
  task automatic results();
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A spent wait counts as a mismatch
  task automatic tmo();
    n_fail++;
    results();
  endtask
  // Ready sampled at the falling edge, so the rising edge consumes settled values
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic a_ok, w_ok, b_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100 && !b_ok; i++) begin
      @(negedge clk);
      a_ok = awv && aw_rdy;
      w_ok = wv && w_rdy;
      b_ok = (b_vld === 1'b1);
      @(posedge clk);
      if (a_ok) awv <= 1'b0;
      if (w_ok) wv <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_ok) tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    logic a_ok, r_ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100 && !r_ok; i++) begin
      @(negedge clk);
      a_ok = arv && ar_rdy;
      r_ok = (r_vld === 1'b1);
      rdata = r_data;
      rresp = r_resp;
      @(posedge clk);
      if (a_ok) arv <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_ok) tmo();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic run_wait();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (sys_rst === 1'b0) break;
    end
    if (i == 3000) tmo();
  endtask
  task automatic trig(input int k);
    @(posedge clk);
    src <= 4'h1 << k;
    @(posedge clk);
    src <= 4'h0;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    run_wait();
    rc(8'h1C, 32'h80);
    rc(8'h20, 32'h0);
    chk("pads", 0, |{pad_oe[47:0], pad_pu, pad_pd});
    for (int k = 0; k < 4; k++) begin
      trig(k);
      run_wait();
      rc(8'h1C, cause[k]);
    end
    // Pod keeps the line low past the sample
    trig(0);
    hold_rst <= 1'b1;
    repeat (100) @(posedge clk);
    hold_rst <= 1'b0;
    run_wait();
    rc(8'h1C, 32'h42);
    hold_rst <= 1'b1;
    repeat (5) @(posedge clk);
    hold_rst <= 1'b0;
    run_wait();
    rc(8'h1C, 32'h40);
    hold_dbg <= 1'b1;
    trig(1);
    run_wait();
    @(posedge clk);
    hold_dbg <= 1'b0;
    chk("bgnd", 1, bgnd);
    rc(8'h20, 32'h1);
    trig(3);
    run_wait();
    chk("bgnd", 0, bgnd);
    @(posedge clk);
    spd <= 1'b1;
    @(negedge clk);
    chk("dbg", 3, {dbg_oe, dbg_out});
    @(posedge clk);
    dbg_lo <= 1'b1;
    @(negedge clk);
    chk("dbg", 2, {dbg_oe, dbg_out});
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h2);
    spd <= 1'b0;
    dbg_lo <= 1'b0;
    rc(8'h00, 32'h2);
    chk("oe", 1, pad_oe[1]);
    p_en[2:1] <= 2'h3;
    @(negedge clk);
    chk("oe", 0, pad_oe[1]);
    rc(8'h00, 32'h2);
    wr(8'h08, 32'h0);
    rc(8'h00, 32'h0);
    wr(8'h10, 32'h4);
    kbi_en <= 4'h2;
    kbi_rise <= 4'h2;
    @(negedge clk);
    chk("pull", 1, pad_pu[2]);
    chk("kbi", 1, {pad_pu[5], pad_pd[5]});
    @(posedge clk);
    kbi_rise <= 4'h0;
    @(negedge clk);
    chk("kbi", 2, {pad_pu[5], pad_pd[5]});
    wr(8'h0C, 32'h10000);
    for (int j = 0; j < 6; j++) begin
      wr(8'h18, {24'h0, ctl[j]});
      @(negedge clk);
      chk("ctrl", cx[j], {irq_lvl, irq_pu, irq_pd, stop_self, range_hi, dbg_oe, dbg_out});
    end
    chk("osc", 1, pad_oe[48]);
    rd(8'h40);
    chk("resp", 2, rresp);
    results();
  end
endmodule
`default_nettype wire
